// file: core/nsx_pkg.sv
package nsx_pkg;

    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int DIR_N = 3;

    // Opcode fields
    localparam logic [5:0] OPC_SWAP = 6'h0e;
    localparam logic [5:0] OPC_XORF = 6'h06;
    localparam logic [1:0] OPC_LIT_HI = 2'h3;
    localparam logic [3:0] OPC_XORL = 4'ha;
    localparam logic [10:0] OPC_DIR = 11'h00c;
    localparam logic [2:0] DIR_SEL_MIN = 3'h5;
    localparam logic [2:0] DIR_SEL_MAX = 3'h7;

    // Field positions
    localparam int OPC6_HI = 13;
    localparam int OPC6_LO = 8;
    localparam int LIT_HI_LO = 12;
    localparam int LIT_NIB_HI = 11;
    localparam int DEST_BIT = 7;
    localparam int DIR_SEL_HI = 2;
    localparam int DIR_PFX_LO = 3;
    localparam int NIB_W = 4;

    // File addresses where the direction registers are mapped
    localparam logic [ADDR_W-1:0] DIR_FILE_ADDR0 = 7'h45;
    localparam logic [ADDR_W-1:0] DIR_FILE_ADDR1 = 7'h46;
    localparam logic [ADDR_W-1:0] DIR_FILE_ADDR2 = 7'h47;

    // Reset values
    localparam logic [DATA_W-1:0] DIR_RESET = 8'hff;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    typedef enum logic [4:0] {
        OP_NONE = 5'b00001,
        OP_SWAP = 5'b00010,
        OP_XORL = 5'b00100,
        OP_XORF = 5'b01000,
        OP_DIR = 5'b10000
    } nsx_op_t;

endpackage

// file: core/nsx_dir_if.sv
`timescale 1ns/10ps
interface nsx_dir_if;
    import nsx_pkg::*;
    logic we;
    logic [1:0] idx;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] q [DIR_N];

    modport ctrl (output we, output idx, output wdata, input q);
    modport bank (input we, input idx, input wdata, output q);
endinterface

// file: core/nsx_dir_bank.sv
`timescale 1ns/10ps
module nsx_dir_bank
    import nsx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Write port and contents
    nsx_dir_if.bank dir
);

    logic [DATA_W-1:0] q_reg [DIR_N];

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DIR_N; i++) begin
                q_reg[i] <= DIR_RESET;
            end
        end else if (dir.we && (dir.idx < 2'(DIR_N))) begin
            q_reg[dir.idx] <= dir.wdata;
        end
    end

    assign dir.q = q_reg;

endmodule

// file: core/nsx_exec.sv
`timescale 1ns/10ps
// Functional notes
// RULE_01: Nibble swap exchanges upper and lower nibbles of addressed file register.
// RULE_02: Swap result goes to accumulator if dest is 0, else file; no flags.
// RULE_03: Literal XOR: accumulator XOR low opcode byte, result into accumulator.
// RULE_04: Register XOR: accumulator XOR file register, dest selects target, zero flag.
// RULE_05: Legacy load copies accumulator into direction register 5..7; no flags.
// RULE_06: Direction registers also readable and writable as ordinary file registers.
// RULE_07: Zero flag set when 8-bit result is zero, cleared otherwise.
module nsx_exec
    import nsx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Instruction in
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic [DATA_W-1:0] file_rdata,
    // Write access from the rest of the core
    input wire logic ext_we,
    input wire logic [ADDR_W-1:0] ext_addr,
    input wire logic [DATA_W-1:0] ext_wdata,
    // File write-back
    output logic file_we,
    output logic [ADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    // Core state
    output logic [DATA_W-1:0] acc,
    output logic zero_flag,
    output logic exec_done,
    output logic [DATA_W-1:0] dir_port5,
    output logic [DATA_W-1:0] dir_port6,
    output logic [DATA_W-1:0] dir_port7
);

    nsx_dir_if dir_bus ();

    nsx_dir_bank u_dir (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .dir(dir_bus.bank)
    );

    nsx_op_t op;
    logic [ADDR_W-1:0] f_addr;
    logic dest;
    logic [DATA_W-1:0] operand;
    logic [DATA_W-1:0] result;
    logic f_is_dir;
    logic ext_is_dir;
    logic [1:0] f_idx;
    logic [1:0] ext_idx;
    logic [DATA_W-1:0] acc_reg;
    logic zero_reg;
    logic file_we_reg;
    logic [ADDR_W-1:0] file_waddr_reg;
    logic [DATA_W-1:0] file_wdata_reg;
    logic done_reg;
    logic [DATA_W-1:0] dir5_reg;
    logic [DATA_W-1:0] dir6_reg;
    logic [DATA_W-1:0] dir7_reg;

    assign f_addr = instr[ADDR_W-1:0];
    assign dest = instr[DEST_BIT];

    // Decode; unknown words leave acc and zero flag untouched and clear exec_done and file_we
    always_comb begin
        op = OP_NONE;
        if (instr_valid) begin
            if (instr[OPC6_HI:OPC6_LO] == OPC_SWAP) begin
                op = OP_SWAP;
            end else if (instr[OPC6_HI:OPC6_LO] == OPC_XORF) begin
                op = OP_XORF;
            end else if (instr[OPC6_HI:LIT_HI_LO] == OPC_LIT_HI
                         && instr[LIT_NIB_HI:OPC6_LO] == OPC_XORL) begin
                op = OP_XORL;
            end else if (instr[OPC6_HI:DIR_PFX_LO] == OPC_DIR
                         && instr[DIR_SEL_HI:0] >= DIR_SEL_MIN) begin
                op = OP_DIR; // see RULE_05
            end
        end
    end

    // Map a file address onto the direction bank
    function automatic logic dir_hit(input logic [ADDR_W-1:0] a, output logic [1:0] idx);
        idx = 2'h0;
        dir_hit = 1'b0;
        if (a == DIR_FILE_ADDR0) begin
            dir_hit = 1'b1;
        end else if (a == DIR_FILE_ADDR1) begin
            dir_hit = 1'b1;
            idx = 2'h1;
        end else if (a == DIR_FILE_ADDR2) begin
            dir_hit = 1'b1;
            idx = 2'h2;
        end
    endfunction

    always_comb begin
        f_is_dir = dir_hit(f_addr, f_idx);
        ext_is_dir = dir_hit(ext_addr, ext_idx);
    end

    // Direction registers shadow the file store at their addresses
    assign operand = f_is_dir ? dir_bus.q[f_idx] : file_rdata; // see RULE_06

    always_comb begin
        result = ZERO_BYTE;
        unique case (op)
            OP_SWAP: result = {operand[NIB_W-1:0], operand[DATA_W-1:NIB_W]}; // see RULE_01
            OP_XORL: result = acc_reg ^ instr[DATA_W-1:0]; // see RULE_03
            OP_XORF: result = acc_reg ^ operand; // see RULE_04
            OP_DIR: result = acc_reg;
            OP_NONE: result = ZERO_BYTE;
        endcase
    end

    // Direction bank writes; an executing instruction wins over the side port
    always_comb begin
        dir_bus.we = 1'b0;
        dir_bus.idx = 2'h0;
        dir_bus.wdata = result;
        if (op == OP_DIR) begin
            dir_bus.we = 1'b1; // see RULE_05
            dir_bus.idx = 2'(instr[DIR_SEL_HI:0] - DIR_SEL_MIN);
        end else if ((op == OP_SWAP || op == OP_XORF) && dest && f_is_dir) begin
            dir_bus.we = 1'b1; // see RULE_06
            dir_bus.idx = f_idx;
        end else if (ext_we && ext_is_dir) begin
            dir_bus.we = 1'b1; // see RULE_06
            dir_bus.idx = ext_idx;
            dir_bus.wdata = ext_wdata;
        end
    end

    // Accumulator
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            acc_reg <= ACC_RESET;
        end else if (op == OP_XORL) begin
            acc_reg <= result; // see RULE_03
        end else if ((op == OP_SWAP || op == OP_XORF) && !dest) begin
            acc_reg <= result; // see RULE_02 see RULE_04
        end
    end

    // Zero flag: only the register XOR and literal XOR touch it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            zero_reg <= 1'b0;
        end else if (op == OP_XORF || op == OP_XORL) begin
            zero_reg <= (result == ZERO_BYTE); // see RULE_04 see RULE_07
        end
    end

    // File write-back; direction addresses are kept out of the file store
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            file_we_reg <= 1'b0;
            file_waddr_reg <= '0;
            file_wdata_reg <= ZERO_BYTE;
        end else begin
            file_we_reg <= (op == OP_SWAP || op == OP_XORF) && dest && !f_is_dir; // see RULE_02
            if ((op == OP_SWAP || op == OP_XORF) && dest) begin
                file_waddr_reg <= f_addr;
                file_wdata_reg <= result;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (op != OP_NONE);
        end
    end

    // Registered copies so the pins come straight from flops
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dir5_reg <= DIR_RESET;
            dir6_reg <= DIR_RESET;
            dir7_reg <= DIR_RESET;
        end else begin
            dir5_reg <= dir_bus.q[0];
            dir6_reg <= dir_bus.q[1];
            dir7_reg <= dir_bus.q[2];
        end
    end

    assign acc = acc_reg;
    assign zero_flag = zero_reg;
    assign file_we = file_we_reg;
    assign file_waddr = file_waddr_reg;
    assign file_wdata = file_wdata_reg;
    assign exec_done = done_reg;
    assign dir_port5 = dir5_reg;
    assign dir_port6 = dir6_reg;
    assign dir_port7 = dir7_reg;

endmodule

// file: tb/nsx_exec_assertions.sv
`timescale 1ns/10ps
module nsx_exec_assertions
    import nsx_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Inputs
    input wire logic instr_valid,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic [DATA_W-1:0] file_rdata,
    input wire logic ext_we,
    input wire logic [ADDR_W-1:0] ext_addr,
    input wire logic [DATA_W-1:0] ext_wdata,
    // Outputs
    input wire logic file_we,
    input wire logic [ADDR_W-1:0] file_waddr,
    input wire logic [DATA_W-1:0] file_wdata,
    input wire logic [DATA_W-1:0] acc,
    input wire logic zero_flag,
    input wire logic exec_done,
    input wire logic [DATA_W-1:0] dir_port5,
    input wire logic [DATA_W-1:0] dir_port6,
    input wire logic [DATA_W-1:0] dir_port7
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // Bank-mapped addresses are left out, their operand is not file_rdata
    wire logic swp = instr_valid && instr[13:8] == OPC_SWAP && instr[6:3] != 4'h8;
    wire logic xf = instr_valid && instr[13:8] == OPC_XORF && instr[6:3] != 4'h8;
    wire logic lit = instr_valid && instr[13:8] == {OPC_LIT_HI, OPC_XORL};
    wire logic dl = instr_valid && instr[13:3] == OPC_DIR;
    sequence dir_req;
        dl && instr[2:0] >= DIR_SEL_MIN;
    endsequence
    sequence ext_req;
        ext_we && ext_addr == DIR_FILE_ADDR1 && !instr_valid;
    endsequence
    swap_acc_a: assert property (swp && !instr[7] |=>
        acc == {$past(file_rdata[3:0]), $past(file_rdata[7:4])} && $stable(zero_flag))
        else $error("swap to acc wrong");
    swap_file_a: assert property (swp && instr[7] |=> file_we && $stable(acc) &&
        file_waddr == $past(instr[6:0]) && file_wdata == {$past(file_rdata[3:0]),
        $past(file_rdata[7:4])}) else $error("swap to file wrong");
    lit_xor_a: assert property (lit |=> exec_done &&
        acc == ($past(acc) ^ $past(instr[7:0])) && zero_flag == (acc == 8'h00))
        else $error("literal xor wrong");
    xorf_acc_a: assert property (xf && !instr[7] |=>
        acc == ($past(acc) ^ $past(file_rdata)) && zero_flag == (acc == 8'h00))
        else $error("register xor to acc wrong");
    xorf_file_a: assert property (xf && instr[7] |=> file_we && $stable(acc) &&
        file_wdata == ($past(acc) ^ $past(file_rdata)) && zero_flag == (file_wdata == 8'h00))
        else $error("register xor to file wrong");
    dir_load_a: assert property (dir_req |=> $stable(zero_flag) ##1
        ($past(instr[1:0], 2) == 2'h1 ? dir_port5 : $past(instr[1:0], 2) == 2'h2 ?
        dir_port6 : dir_port7) == $past(acc, 2)) else $error("port load wrong");
    ext_dir_a: assert property (ext_req |=> ##1 dir_port6 == $past(ext_wdata, 2))
        else $error("mapped direction write wrong");
    refuse_a: assert property (dl && instr[2:0] < DIR_SEL_MIN |=>
        !exec_done && !file_we && $stable(acc)) else $error("bad port load acted");
endmodule
bind nsx_exec nsx_exec_assertions chk (.sys_clk(sys_clk), .rstn(rstn),
    .instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata), .ext_we(ext_we),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .acc(acc), .zero_flag(zero_flag), .exec_done(exec_done),
    .dir_port5(dir_port5), .dir_port6(dir_port6), .dir_port7(dir_port7));

// file: tb/nsx_exec_tb.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module nsx_exec_tb
    import nsx_pkg::*;
;
    logic sys_clk = 0, rstn = 0, instr_valid = 0, ext_we = 0, file_we, zero_flag, exec_done;
    logic [13:0] instr = 14'h0;
    logic [6:0] ext_addr = 7'h0, file_waddr;
    logic [7:0] file_rdata = 8'h0, ext_wdata = 8'h0, file_wdata, acc;
    logic [7:0] dir_port5, dir_port6, dir_port7, m_acc = 8'h0;
    logic [7:0] m_dir [3] = '{8'hff, 8'hff, 8'hff};
    logic m_z = 0;
    int err_total = 0, num_checks = 0, seed = 32'h3f4b;
    nsx_exec dut (.sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
        .file_rdata(file_rdata), .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata), .acc(acc),
        .zero_flag(zero_flag), .exec_done(exec_done), .dir_port5(dir_port5),
        .dir_port6(dir_port6), .dir_port7(dir_port7));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Called at a falling edge; back-to-back calls give one request per cycle
    task automatic run_op(input int k);
        logic [6:0] f;
        logic [7:0] r, lit, op, res;
        logic d, dir, we, done;
        r = $random(seed);
        lit = $random(seed);
        f = $random(seed);
        if (f[6]) f = 7'h45 + 7'(r[1:0] % 2'h3);
        d = lit[0];
        dir = f[6];
        op = dir ? m_dir[f - 7'h45] : r;
        we = 0;
        done = k != 4;
        instr_valid = k != 4;
        // A side write that meets a port load must be dropped
        ext_we = k == 4 || (k == 3 && lit[1]);
        ext_addr = f;
        ext_wdata = r;
        file_rdata = r;
        res = k == 0 ? {op[3:0], op[7:4]} : k == 1 ? m_acc ^ lit : m_acc ^ op;
        case (k)
            0: instr = {OPC_SWAP, d, f};
            1: instr = {OPC_LIT_HI, OPC_XORL, lit};
            2: instr = {OPC_XORF, d, f};
            3: instr = {OPC_DIR, f[2:0]};
            default: instr = {OPC_XORF, d, f};
        endcase
        if (k == 1 || k == 2) m_z = res == 8'h00;
        if (k == 1 || (!d && (k == 0 || k == 2))) m_acc = res;
        else if (d && (k == 0 || k == 2) && dir) m_dir[f - 7'h45] = res;
        else if (d && (k == 0 || k == 2)) we = 1;
        if (k == 3) done = f[2:0] >= DIR_SEL_MIN;
        if (k == 3 && done) m_dir[f[1:0] - 2'h1] = m_acc;
        if (k == 4 && dir) m_dir[f - 7'h45] = r;
        @(negedge sys_clk);
        `CHK("exec_done", done, exec_done)
        `CHK("file_we", we, file_we)
        `CHK("acc", m_acc, acc)
        `CHK("zero_flag", m_z, zero_flag)
        if (we) `CHK("file_waddr", f, file_waddr)
        if (we) `CHK("file_wdata", res, file_wdata)
    endtask
    initial begin
        repeat (20) @(negedge sys_clk);
        rstn = 1;
        `CHK("dir_port5", 8'hff, dir_port5)
        for (int i = 0; i < 500; i++) run_op({$random(seed)} % 5);
        $display("test random ops done");
        instr_valid = 0;
        ext_we = 0;
        repeat (3) @(negedge sys_clk);
        `CHK("dir_port5", m_dir[0], dir_port5)
        `CHK("dir_port6", m_dir[1], dir_port6)
        `CHK("dir_port7", m_dir[2], dir_port7)
        $display("test direction ports done");
        complete_run;
    end
    // Roughly four times the expected run
    initial begin
        #(100 * 2200);
        err_total++;
        complete_run;
    end
endmodule
